// ---- src/phap_host_port.sv ----
// host access engine of the colour lookup palette
`timescale 1ns/1ps
`default_nettype none
`include "phap_consts.svh"
// Behaviour
// - select code picks index load per mode, palette data, mask, overlay data, reserved.
// - one eight-bit index addresses palette and overlay entries, lsb on bit zero.
// - palette write collects red, green, blue; blue write stores joined word.
// - index advances after each completed blue write.
// - index load in read mode prefetches entry, then index advances.
// - three reads return red, green, blue; blue read prefetches next, advances.
// - overlay write collects three colours, stores on blue, then advances.
// - overlay read load and each blue read prefetch overlay entry, advance.
// - palette index wraps from last entry to first.
// - overlay select uses only low four index bits.
// - overlay nibble zero reserved; one to fifteen are overlay colours.
// - storage transfers happen internally between host accesses.
// - hidden phase counter counts modulo three red, green, blue.
// - index write clears phase counter; index read does not.
// - index read changes neither index, phase nor mode.
// - six-bit mode uses bits 0 to 5; upper bits ignored, read zero.
// - width select high gives eight-bit colour, low gives six-bit.
module phap_host_port
  import phap_pkg::*;
#(
  parameter int CW = 8
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            srst,
  // host bus, one-cycle strobes
  input  wire logic [2:0]      register_select,
  input  wire logic            host_wr,
  input  wire logic            host_rd,
  input  wire logic [7:0]      host_wdata,
  input  wire logic            wide_color,
  output logic      [7:0]      host_rdata_ff,
  // pixel side
  input  wire logic [7:0]      pix_addr,
  input  wire logic [3:0]      pix_ovl,
  output logic      [7:0]      pixel_index_mask_ff,
  output logic      [3*CW-1:0] pix_word_ff
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    // host-visible index, hidden phase and access mode
    logic [7:0]      idx;
    logic [1:0]      phase;
    phap_mode_t      mode;
    // colour holding registers
    logic [CW-1:0]   hold_r;
    logic [CW-1:0]   hold_g;
    logic [CW-1:0]   hold_b;
    // prefetch request and storage write request
    logic            fetch;
    logic            pal_we;
    logic            ovl_we;
    logic [7:0]      wr_addr;
    logic [3*CW-1:0] wr_word;
    // mask, read data and pixel word
    logic [7:0]      mask;
    logic [7:0]      rdata;
    logic [3*CW-1:0] pix;
  } phap_state_t;

  phap_state_t st_ff;
  phap_state_t nxt_st;
  logic [3*CW-1:0] pal_rd_word;
  logic [3*CW-1:0] ovl_rd_word;
  logic [3*CW-1:0] pix_word;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // colour byte as taken from the bus for the selected width
  function automatic logic [CW-1:0] take_color(input logic [7:0] d, input logic wide);
    take_color = wide ? d[CW-1:0] : CW'(d[`PHAP_NARROW_W-1:0]);
  endfunction

  // colour byte as driven to the bus
  function automatic logic [7:0] give_color(input logic [CW-1:0] c, input logic wide);
    give_color = wide ? 8'(c) : 8'(c[`PHAP_NARROW_W-1:0]);
  endfunction

  // is this code a colour data access of either family, palette or overlay
  function automatic logic is_data(input logic [2:0] rs);
    is_data = (rs == `PHAP_RS_PAL_DATA) || (rs == `PHAP_RS_OVL_DATA);
  endfunction

  // phase after one colour data access, back to red after blue
  function automatic logic [1:0] next_phase(input logic [1:0] ph);
    next_phase = (ph == `PHAP_PH_BLUE) ? `PHAP_PH_RED : ph + 2'h1;
  endfunction

  // index load codes that open a read mode and so prefetch
  function automatic logic is_read_load(input logic [2:0] rs);
    is_read_load = (rs == `PHAP_RS_IDX_RD) || (rs == `PHAP_RS_OVL_RD);
  endfunction

  // access mode opened by an index load code
  function automatic phap_mode_t load_mode(input logic [2:0] rs);
    unique case (rs)
      `PHAP_RS_IDX_WR: load_mode = PHAP_M_PAL_WR;
      `PHAP_RS_IDX_RD: load_mode = PHAP_M_PAL_RD;
      `PHAP_RS_OVL_WR: load_mode = PHAP_M_OVL_WR;
      default:         load_mode = PHAP_M_OVL_RD;
    endcase
  endfunction

  // holding register that the phase puts on the bus
  function automatic logic [CW-1:0] pick_hold(input logic [1:0]    ph,
                                              input logic [CW-1:0] r,
                                              input logic [CW-1:0] g,
                                              input logic [CW-1:0] b);
    unique case (ph)
      `PHAP_PH_RED:   pick_hold = r;
      `PHAP_PH_GREEN: pick_hold = g;
      default:        pick_hold = b;
    endcase
  endfunction

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  phap_color_store #(.CW(CW)) u_store (
    .clk         (clk),
    .pal_we      (st_ff.pal_we),
    .ovl_we      (st_ff.ovl_we),
    .wr_addr     (st_ff.wr_addr),
    .wr_word     (st_ff.wr_word),
    .rd_addr     (st_ff.idx),
    .pal_rd_word (pal_rd_word),
    .ovl_rd_word (ovl_rd_word),
    .pix_addr    (pix_addr & st_ff.mask),
    .pix_ovl     (pix_ovl),
    .pix_word    (pix_word)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    // start from the held state, strobes last one cycle
    nxt_st        = st_ff;
    nxt_st.pal_we = 1'b0;
    nxt_st.ovl_we = 1'b0;
    nxt_st.fetch  = 1'b0;
    nxt_st.pix    = pix_word;

    // ----------------------------------------------------------
    // prefetch into the holding registers
    // ----------------------------------------------------------
    // one cycle after the triggering access, in the gap before the next strobe
    if (st_ff.fetch) begin
      if (st_ff.mode == PHAP_M_OVL_RD) begin
        {nxt_st.hold_r, nxt_st.hold_g, nxt_st.hold_b} = ovl_rd_word;
      end else begin
        {nxt_st.hold_r, nxt_st.hold_g, nxt_st.hold_b} = pal_rd_word;
      end
      nxt_st.idx = st_ff.idx + 8'h01; // wraps naturally at last entry
    end

    // ----------------------------------------------------------
    // host write strobe, wins over a read in the same cycle
    // ----------------------------------------------------------
    if (host_wr) begin
      unique case (register_select)
        `PHAP_RS_IDX_WR, `PHAP_RS_IDX_RD, `PHAP_RS_OVL_WR, `PHAP_RS_OVL_RD: begin
          // index load: new index, phase back to red, mode from the code
          nxt_st.idx   = host_wdata;
          nxt_st.phase = `PHAP_PH_RED;
          nxt_st.mode  = load_mode(register_select);
          // read modes prefetch the loaded entry; a load overrides the index step of a pending one
          nxt_st.fetch = is_read_load(register_select);
        end
        `PHAP_RS_PAL_DATA, `PHAP_RS_OVL_DATA: begin
          unique case (st_ff.phase)
            `PHAP_PH_RED:   nxt_st.hold_r = take_color(host_wdata, wide_color);
            `PHAP_PH_GREEN: nxt_st.hold_g = take_color(host_wdata, wide_color);
            default:        nxt_st.hold_b = take_color(host_wdata, wide_color);
          endcase
          nxt_st.phase = next_phase(st_ff.phase);
          // blue completes the word; a prefetch in the same cycle has
          // already stepped the index, so the store follows nxt_st.idx
          if (st_ff.phase == `PHAP_PH_BLUE) begin
            nxt_st.wr_addr = nxt_st.idx;
            nxt_st.wr_word = {st_ff.hold_r, st_ff.hold_g,
                              take_color(host_wdata, wide_color)};
            nxt_st.pal_we  = (register_select == `PHAP_RS_PAL_DATA);
            nxt_st.ovl_we  = (register_select == `PHAP_RS_OVL_DATA);
            nxt_st.idx     = nxt_st.idx + 8'h01;
          end
        end
        `PHAP_RS_MASK: nxt_st.mask = host_wdata;
        default: ;
      endcase
    end else if (host_rd) begin
      // host read strobe: index, colour, mask or reserved
      unique case (register_select)
        `PHAP_RS_IDX_WR, `PHAP_RS_IDX_RD, `PHAP_RS_OVL_WR, `PHAP_RS_OVL_RD: begin
          nxt_st.rdata = st_ff.idx;
        end
        `PHAP_RS_PAL_DATA, `PHAP_RS_OVL_DATA: begin
          // serve from the holding registers as they stand after any prefetch
          nxt_st.rdata = give_color(pick_hold(st_ff.phase, nxt_st.hold_r, nxt_st.hold_g,
                                              nxt_st.hold_b), wide_color);
          nxt_st.phase = next_phase(st_ff.phase);
          // blue read schedules the prefetch of the entry at the new index
          nxt_st.fetch = (st_ff.phase == `PHAP_PH_BLUE) && is_data(register_select);
        end
        `PHAP_RS_MASK: nxt_st.rdata = st_ff.mask;
        default:       nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff       <= '0;
      st_ff.idx   <= `PHAP_IDX_RESET;
      st_ff.mask  <= `PHAP_MASK_RESET;
      st_ff.phase <= `PHAP_PH_RED;
      st_ff.mode  <= PHAP_M_PAL_WR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output is a field of the state register
  assign host_rdata_ff       = st_ff.rdata;
  assign pixel_index_mask_ff = st_ff.mask;
  assign pix_word_ff         = st_ff.pix;
endmodule
`default_nettype wire

// ---- include/phap_consts.svh ----
// constants for the palette host access port
`ifndef PHAP_CONSTS_SVH
`define PHAP_CONSTS_SVH
`define PHAP_RS_IDX_WR   3'h0
`define PHAP_RS_PAL_DATA 3'h1
`define PHAP_RS_MASK     3'h2
`define PHAP_RS_IDX_RD   3'h3
`define PHAP_RS_OVL_WR   3'h4
`define PHAP_RS_OVL_DATA 3'h5
`define PHAP_RS_RSVD     3'h6
`define PHAP_RS_OVL_RD   3'h7
`define PHAP_PH_RED      2'h0
`define PHAP_PH_GREEN    2'h1
`define PHAP_PH_BLUE     2'h2
`define PHAP_IDX_RESET   8'h00
`define PHAP_MASK_RESET  8'hFF
`define PHAP_IDX_LAST    8'hFF
`define PHAP_NARROW_W    6
`endif

// ---- include/phap_pkg.sv ----
// types for the palette host access port
package phap_pkg;
  // host access mode, gray coded along write, read paths
  typedef enum logic [1:0] {
    PHAP_M_PAL_WR = 2'b00,
    PHAP_M_PAL_RD = 2'b01,
    PHAP_M_OVL_RD = 2'b11,
    PHAP_M_OVL_WR = 2'b10
  } phap_mode_t;
endpackage

// ---- src/phap_color_store.sv ----
// palette and overlay colour storage with pixel-side read ports
`timescale 1ns/1ps
`default_nettype none
module phap_color_store #(
  parameter int CW = 8
) (
  // clock
  input  wire logic            clk,
  // host write
  input  wire logic            pal_we,
  input  wire logic            ovl_we,
  input  wire logic [7:0]      wr_addr,
  input  wire logic [3*CW-1:0] wr_word,
  // host read
  input  wire logic [7:0]      rd_addr,
  output logic      [3*CW-1:0] pal_rd_word,
  output logic      [3*CW-1:0] ovl_rd_word,
  // pixel side
  input  wire logic [7:0]      pix_addr,
  input  wire logic [3:0]      pix_ovl,
  output logic      [3*CW-1:0] pix_word
);
  logic [3*CW-1:0] pal_mem [256];
  logic [3*CW-1:0] ovl_mem [16];

  // storage writes; overlay entry 0 is never written
  always_ff @(posedge clk) begin
    if (pal_we) begin
      pal_mem[wr_addr] <= wr_word;
    end
    if (ovl_we && wr_addr[3:0] != 4'h0) begin
      ovl_mem[wr_addr[3:0]] <= wr_word;
    end
  end

  // reads are combinational, sampled by the host engine
  assign pal_rd_word = pal_mem[rd_addr];
  assign ovl_rd_word = (rd_addr[3:0] == 4'h0) ? '0 : ovl_mem[rd_addr[3:0]];

  // pixel lookup, registered
  always_ff @(posedge clk) begin
    pix_word <= (pix_ovl != 4'h0) ? ovl_mem[pix_ovl] : pal_mem[pix_addr];
  end
endmodule
`default_nettype wire

// ---- tb/phap_host_port_asserts.sv ----
// checker for the palette host access port
`timescale 1ns/1ps
`default_nettype none
module phap_host_port_asserts #(
  parameter int CW = 8
) (
  input wire logic            clk,
  input wire logic            srst,
  input wire logic [2:0]      register_select,
  input wire logic            host_wr,
  input wire logic            host_rd,
  input wire logic [7:0]      host_wdata,
  input wire logic            wide_color,
  input wire logic [7:0]      host_rdata_ff,
  input wire logic [7:0]      pix_addr,
  input wire logic [3:0]      pix_ovl,
  input wire logic [7:0]      pixel_index_mask_ff,
  input wire logic [3*CW-1:0] pix_word_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // read strobe without a competing write
  logic rdo;
  assign rdo = host_rd & ~host_wr;
  AST_RSVD_RD: assert property (rdo && register_select == 3'h6 |=> host_rdata_ff == 8'h00)
    else $error("reserved read not zero");
  AST_NARROW: assert property (rdo && register_select == 3'h1 && !wide_color
    |=> host_rdata_ff[7:6] == 2'h0) else $error("narrow read upper bits set");
  AST_MASK_WR: assert property (host_wr && register_select == 3'h2
    |=> pixel_index_mask_ff == $past(host_wdata)) else $error("mask not written");
  AST_MASK_RD: assert property (rdo && register_select == 3'h2
    |=> host_rdata_ff == $past(pixel_index_mask_ff)) else $error("mask read wrong");
  AST_IDX_LOAD: assert property (host_wr && register_select == 3'h0 ##1 !host_wr
    ##1 rdo && register_select == 3'h0 |=> host_rdata_ff == $past(host_wdata, 3))
    else $error("index read differs from load");
  AST_IDX_KEEP: assert property (rdo && register_select == 3'h0 ##1 !host_wr
    ##1 rdo && register_select == 3'h0 |=> $stable(host_rdata_ff))
    else $error("index read changed index");
  AST_HOLD: assert property (!host_rd |=> $stable(host_rdata_ff))
    else $error("read data moved without a read");
  AST_MASK_RST: assert property (disable iff (1'b0) srst |=> pixel_index_mask_ff == 8'hFF)
    else $error("mask reset value wrong");
endmodule
bind phap_host_port phap_host_port_asserts #(.CW(CW)) u_chk (.*);
`default_nettype wire

// ---- tb/phap_host_model.sv ----
// host bus master model for the palette host access port
`timescale 1ns/1ps
`default_nettype none
module phap_host_model (
  // clock
  input  wire logic       clk,
  // host bus
  output logic      [2:0] register_select,
  output logic            host_wr,
  output logic            host_rd,
  output logic      [7:0] host_wdata,
  input  wire logic [7:0] host_rdata_ff
);
  // idle bus at time zero
  initial begin
    register_select = 3'h6;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end
  // write strobe, then an idle cycle that leaves room for prefetch
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    register_select = sel;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clk);
    host_wr = 1'b0;
    host_wdata = ~d; // released bus shows no stale value
    @(negedge clk);
  endtask
  // read strobe, data taken once registered
  task automatic rd(input logic [2:0] sel, output logic [7:0] d);
    register_select = sel;
    host_rd = 1'b1;
    @(negedge clk);
    d = host_rdata_ff;
    host_rd = 1'b0;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- tb/test_phap_host_port.sv ----
// self-checking bench for the palette host access port
`timescale 1ns/1ps
`default_nettype none
module test_phap_host_port;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        wide_color = 1'b1;
  logic [7:0]  pix_addr = 8'h00;
  logic [3:0]  pix_ovl = 4'h0;
  logic [2:0]  register_select;
  logic        host_wr;
  logic        host_rd;
  logic [7:0]  host_wdata;
  logic [7:0]  host_rdata_ff;
  logic [7:0]  pixel_index_mask_ff;
  logic [23:0] pix_word_ff;
  logic [7:0]  d;
  int          err_count = 0;
  int          checked = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  phap_host_port #(.CW(8)) uut (.clk(clk), .srst(srst), .register_select(register_select),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .wide_color(wide_color),
    .host_rdata_ff(host_rdata_ff), .pix_addr(pix_addr), .pix_ovl(pix_ovl),
    .pixel_index_mask_ff(pixel_index_mask_ff), .pix_word_ff(pix_word_ff));
  phap_host_model host (.clk(clk), .register_select(register_select), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_ff(host_rdata_ff));
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdc(input logic [2:0] sel, input logic [7:0] exp);
    host.rd(sel, d);
    chk("rdata", {16'h0000, d}, {16'h0000, exp});
  endtask
  // red, green, blue triplets
  task automatic wr3(input logic [2:0] sel, input logic [23:0] c);
    host.wr(sel, c[23:16]);
    host.wr(sel, c[15:8]);
    host.wr(sel, c[7:0]);
  endtask
  task automatic rd3(input logic [2:0] sel, input logic [23:0] c);
    rdc(sel, c[23:16]);
    rdc(sel, c[15:8]);
    rdc(sel, c[7:0]);
  endtask
  // pixel lookup, two cycles of latency
  task automatic pxc(input logic [7:0] a, input logic [3:0] o, input logic [23:0] exp);
    pix_addr = a;
    pix_ovl = o;
    repeat (3) @(negedge clk);
    chk("pix_word", pix_word_ff, exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #1000000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rdc(3'h2, 8'hFF);
    host.wr(3'h0, 8'h05);
    host.wr(3'h1, 8'h99);
    host.wr(3'h0, 8'h05);
    wr3(3'h1, 24'h112233);
    wr3(3'h1, 24'h445566);
    rdc(3'h0, 8'h07);
    rdc(3'h0, 8'h07);
    pxc(8'h05, 4'h0, 24'h112233);
    $display("test palette write done");
    host.wr(3'h3, 8'h05);
    rd3(3'h1, 24'h112233);
    rd3(3'h1, 24'h445566);
    rdc(3'h0, 8'h08);
    host.wr(3'h0, 8'hFF);
    wr3(3'h1, 24'hABCDEF);
    rdc(3'h0, 8'h00);
    host.wr(3'h0, 8'h20);
    host.wr(3'h1, 8'hAA);
    rdc(3'h0, 8'h20);
    host.wr(3'h1, 8'hBB);
    host.wr(3'h1, 8'hCC);
    rdc(3'h0, 8'h21);
    pxc(8'h20, 4'h0, 24'hAABBCC);
    $display("test palette read and wrap done");
    host.wr(3'h4, 8'hF3);
    wr3(3'h5, 24'h0A0B0C);
    rdc(3'h0, 8'hF4);
    pxc(8'h00, 4'h3, 24'h0A0B0C);
    host.wr(3'h7, 8'h03);
    rd3(3'h5, 24'h0A0B0C);
    host.wr(3'h4, 8'hA0);
    wr3(3'h5, 24'h123456);
    host.wr(3'h7, 8'hB0);
    rd3(3'h5, 24'h000000);
    $display("test overlay done");
    wide_color = 1'b0;
    host.wr(3'h0, 8'h10);
    wr3(3'h1, 24'hC1C2C3);
    host.wr(3'h3, 8'h10);
    rd3(3'h1, 24'h010203);
    host.wr(3'h3, 8'h06);
    rd3(3'h1, 24'h041526);
    wide_color = 1'b1;
    host.wr(3'h2, 8'h0F);
    chk("mask", {16'h0000, pixel_index_mask_ff}, 24'h00000F);
    rdc(3'h2, 8'h0F);
    pxc(8'hF5, 4'h0, 24'h112233);
    host.wr(3'h6, 8'h55);
    rdc(3'h6, 8'h00);
    rdc(3'h0, 8'h08);
    $display("test width, mask and reserved done");
    print_verdict();
  end
endmodule
`default_nettype wire
